// file: read_wrap_latency_boot_config.v
// boot configuration register for read wrap and latency, with its serial access
`timescale 1ns/100ps
`include "read_boot_config_regs.vh"


module read_wrap_latency_boot_config
(
    input  wire        clock_i,
    input  wire        reset_i,
    input  wire        sck_i,
    input  wire        cs_n_i,
    input  wire        si_i,
    output reg         so_o,
    output reg         so_oe_o,
    input  wire        hard_reset_i,
    input  wire        soft_reset_i,
    input  wire [7:0]  read_opcode_i,
    input  wire [31:0] read_addr_i,
    output wire [4:0]  latency_cycles_o,
    output wire        wrap_active_o,
    output wire [31:0] read_addr_next_o,
    output wire [7:0]  boot_config_o,
    output wire [7:0]  live_config_o,
    output wire        wrap_on_o,
    output wire [1:0]  wrap_size_o,
    output wire [3:0]  latency_code_o
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg  [1:0]  sck_sync;
    reg  [1:0]  cs_n_sync;
    reg  [1:0]  si_sync;
    reg  [1:0]  hard_sync;
    reg         sck_prev;
    reg         hard_prev;
    wire        sck_rise;
    wire        sck_fall;
    wire        cs_low;
    wire        hard_rise;

    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sck_sync  <= 2'h0;
            cs_n_sync <= 2'h3;
            si_sync   <= 2'h0;
            hard_sync <= 2'h0;
            sck_prev  <= 1'b0;
            hard_prev <= 1'b0;
        end
        else
        begin
            sck_sync  <= {sck_sync[0], sck_i};
            cs_n_sync <= {cs_n_sync[0], cs_n_i};
            si_sync   <= {si_sync[0], si_i};
            hard_sync <= {hard_sync[0], hard_reset_i};
            sck_prev  <= sck_sync[1];
            hard_prev <= hard_sync[1];
        end
    end

    assign sck_rise  = sck_sync[1] && !sck_prev;
    assign sck_fall  = !sck_sync[1] && sck_prev;
    assign cs_low    = !cs_n_sync[1];
    assign hard_rise = hard_sync[1] && !hard_prev;

    // ****************************************************************
    // serial engine and registers
    // ****************************************************************
    reg  [7:0]  boot_config;
    reg  [7:0]  live_config;
    reg  [2:0]  state;
    reg  [4:0]  bit_cnt;
    reg  [7:0]  shift_in;
    reg  [7:0]  opcode;
    reg  [23:0] reg_addr;
    reg  [2:0]  byte_idx;
    reg  [4:0]  dummy_cnt;
    reg  [7:0]  shift_out;
    reg         write_unlocked;
    reg         write_seen;
    wire [7:0]  next_byte;
    wire [23:0] next_addr;
    wire [4:0]  reg_read_dummy;
    wire [7:0]  read_value;
    wire        store_boot;

    assign next_byte = {shift_in[6:0], si_sync[1]};
    assign next_addr = {reg_addr[22:0], si_sync[1]};

    // unmapped addresses read as zero
    assign read_value = (reg_addr == `BOOT_CFG_ADDR) ? boot_config
                      : (reg_addr == `LIVE_CFG_ADDR) ? live_config : 8'h00;

    // write-registers carries this register as its fourth byte
    assign store_boot = write_unlocked &&
                        (((opcode == `OP_WRITE_REGS) && (byte_idx == `WRITE_REGS_CFG_BYTE)) ||
                         ((opcode == `OP_WRITE_ANY_REG) && (reg_addr == `BOOT_CFG_ADDR)));

    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            boot_config    <= `BOOT_CFG_DEFAULT;
            live_config    <= `BOOT_CFG_DEFAULT;
            state          <= `ST_CMD;
            bit_cnt        <= 5'h00;
            shift_in       <= 8'h00;
            opcode         <= 8'h00;
            reg_addr       <= 24'h000000;
            byte_idx       <= 3'h0;
            dummy_cnt      <= 5'h00;
            shift_out      <= 8'h00;
            write_unlocked <= 1'b0;
            write_seen     <= 1'b0;
            so_o           <= 1'b0;
            so_oe_o        <= 1'b0;
        end
        else
        begin
            // boot copy governs after any reset, live copy thereafter
            if (hard_rise || soft_reset_i)
                live_config <= boot_config;
            so_oe_o <= cs_low && (state == `ST_RDATA);
            if (!cs_low)
            begin
                state    <= `ST_CMD;
                bit_cnt  <= 5'h00;
                byte_idx <= 3'h0;
                // unlock lasts for exactly one write command
                if (write_seen)
                begin
                    write_unlocked <= 1'b0;
                    write_seen     <= 1'b0;
                end
            end
            else if (sck_rise)
            begin
                shift_in <= next_byte;
                bit_cnt  <= bit_cnt + 5'h01;
                case (state)
                    `ST_CMD:
                    begin
                        if (bit_cnt == `CMD_LAST_BIT)
                        begin
                            opcode  <= next_byte;
                            bit_cnt <= 5'h00;
                            case (next_byte)
                                `OP_PERSIST_UNLOCK:
                                begin
                                    write_unlocked <= 1'b1;
                                    state          <= `ST_IGNORE;
                                end
                                `OP_WRITE_REGS:
                                begin
                                    write_seen <= 1'b1;
                                    state      <= `ST_WDATA;
                                end
                                `OP_WRITE_ANY_REG:
                                begin
                                    write_seen <= 1'b1;
                                    state      <= `ST_ADDR;
                                end
                                `OP_READ_ANY_REG:
                                    state <= `ST_ADDR;
                                default:
                                    state <= `ST_IGNORE;
                            endcase
                        end
                    end
                    `ST_ADDR:
                    begin
                        reg_addr <= next_addr;
                        if (bit_cnt == `ADDR_LAST_BIT)
                        begin
                            bit_cnt <= 5'h00;
                            if (opcode == `OP_WRITE_ANY_REG)
                                state <= `ST_WDATA;
                            else
                            begin
                                dummy_cnt <= reg_read_dummy;
                                state     <= `ST_DUMMY;
                            end
                        end
                    end
                    `ST_WDATA:
                    begin
                        if (bit_cnt == `CMD_LAST_BIT)
                        begin
                            bit_cnt <= 5'h00;
                            if (store_boot)
                                boot_config <= {1'b0, next_byte[6:0]};
                            if (byte_idx != 3'h7)
                                byte_idx <= byte_idx + 3'h1;
                        end
                    end
                    `ST_DUMMY:
                    begin
                        dummy_cnt <= dummy_cnt - 5'h01;
                        // data only after the last latency cycle
                        if (dummy_cnt == 5'h01)
                        begin
                            shift_out <= read_value;
                            state     <= `ST_RDATA;
                        end
                    end
                    `ST_RDATA:
                        bit_cnt <= 5'h00;
                    `ST_IGNORE:
                        bit_cnt <= 5'h00;
                    default:
                        state <= `ST_IGNORE;
                endcase
            end
            else if (sck_fall && (state == `ST_RDATA))
            begin
                // rotating the byte repeats it for as long as the host clocks
                so_o      <= shift_out[7];
                shift_out <= {shift_out[6:0], shift_out[7]};
            end
        end
    end

    // ****************************************************************
    // latency and wrap decode
    // ****************************************************************
    read_timing_decode reg_read_timing
    (
        .opcode_i       (`OP_READ_ANY_REG),
        .live_config_i  (live_config),
        .addr_i         (32'h00000000),
        .dummy_cycles_o (reg_read_dummy),
        .wrap_active_o  (),
        .addr_next_o    ()
    );

    read_timing_decode array_read_timing
    (
        .opcode_i       (read_opcode_i),
        .live_config_i  (live_config),
        .addr_i         (read_addr_i),
        .dummy_cycles_o (latency_cycles_o),
        .wrap_active_o  (wrap_active_o),
        .addr_next_o    (read_addr_next_o)
    );

    assign boot_config_o  = boot_config;
    assign live_config_o  = live_config;
    assign wrap_on_o      = !live_config[`CFG_WRAP_OFF_BIT];
    assign wrap_size_o    = live_config[`CFG_WRAP_SIZE_HI:`CFG_WRAP_SIZE_LO];
    assign latency_code_o = live_config[`CFG_LAT_HI:`CFG_LAT_LO];

endmodule // read_wrap_latency_boot_config

// file: read_boot_config_regs.vh
// constants for the read wrap / latency boot configuration block
`ifndef READ_BOOT_CONFIG_REGS_VH
`define READ_BOOT_CONFIG_REGS_VH

// ****************************************************************
// register addresses reached with the any-register commands
// ****************************************************************
`define BOOT_CFG_ADDR          24'h000004
`define LIVE_CFG_ADDR          24'h000070

// ****************************************************************
// field layout and factory default
// ****************************************************************
`define CFG_RSVD_BIT           7
`define CFG_WRAP_SIZE_HI       6
`define CFG_WRAP_SIZE_LO       5
`define CFG_WRAP_OFF_BIT       4
`define CFG_LAT_HI             3
`define CFG_LAT_LO             0
`define BOOT_CFG_DEFAULT       8'h70
`define WRITE_REGS_CFG_BYTE    3'h3

// ****************************************************************
// latency figures in dummy cycles
// ****************************************************************
`define LAT_CODE_ZERO          4'h0
`define LAT_ZERO_DUMMY         5'h08
`define LAT_FIXED_DUMMY        5'h01
`define LAT_NONE               5'h00

// ****************************************************************
// command opcodes
// ****************************************************************
`define OP_PERSIST_UNLOCK      8'h06
`define OP_WRITE_REGS          8'h01
`define OP_WRITE_ANY_REG       8'h71
`define OP_READ_ANY_REG        8'h65
`define OP_FAST_READ           8'h0b
`define OP_FAST_READ4          8'h0c
`define OP_DUAL_OUT_READ       8'h3b
`define OP_DUAL_OUT_READ4      8'h3c
`define OP_QUAD_OUT_READ       8'h6b
`define OP_QUAD_OUT_READ4      8'h6c
`define OP_DUAL_IO_READ        8'hbb
`define OP_DUAL_IO_READ4       8'hbc
`define OP_QUAD_IO_READ        8'heb
`define OP_QUAD_IO_READ4       8'hec
`define OP_DDR_QUAD_READ       8'hed
`define OP_DDR_QUAD_READ4      8'hee
`define OP_SECURITY_READ       8'h4b
`define OP_PARAMS_READ         8'h5a
`define OP_LEARN_PATTERN_READ  8'h41
`define OP_PROT_BITS_READ      8'h2b
`define OP_PROT_REG_READ       8'ha7
`define OP_PASSWORD_READ       8'he7

// ****************************************************************
// serial engine states
// ****************************************************************
`define ST_CMD                 3'h0
`define ST_ADDR                3'h1
`define ST_WDATA               3'h2
`define ST_DUMMY               3'h3
`define ST_RDATA               3'h4
`define ST_IGNORE              3'h5
`define CMD_LAST_BIT           5'h07
`define ADDR_LAST_BIT          5'h17

`endif

// file: read_timing_decode.v
// latency and burst wrap decode for one read command
`timescale 1ns/100ps
`include "read_boot_config_regs.vh"

module read_timing_decode
(
    input  wire [7:0]  opcode_i,
    input  wire [7:0]  live_config_i,
    input  wire [31:0] addr_i,
    output reg  [4:0]  dummy_cycles_o,
    output wire        wrap_active_o,
    output wire [31:0] addr_next_o
);

    wire [3:0]  lat_code;
    wire [1:0]  wrap_size;
    wire        wrap_cmd;
    wire [31:0] wrap_mask;
    wire [31:0] addr_inc;

    assign lat_code  = live_config_i[`CFG_LAT_HI:`CFG_LAT_LO];
    assign wrap_size = live_config_i[`CFG_WRAP_SIZE_HI:`CFG_WRAP_SIZE_LO];

    // ****************************************************************
    // dummy cycles
    // ****************************************************************
    always @*
    begin
        case (opcode_i)
            `OP_LEARN_PATTERN_READ, `OP_PROT_BITS_READ,
            `OP_PROT_REG_READ, `OP_PASSWORD_READ:
                dummy_cycles_o = `LAT_FIXED_DUMMY;
            `OP_FAST_READ, `OP_FAST_READ4, `OP_DUAL_OUT_READ, `OP_DUAL_OUT_READ4,
            `OP_QUAD_OUT_READ, `OP_QUAD_OUT_READ4, `OP_DUAL_IO_READ,
            `OP_DUAL_IO_READ4, `OP_QUAD_IO_READ, `OP_QUAD_IO_READ4,
            `OP_DDR_QUAD_READ, `OP_DDR_QUAD_READ4, `OP_SECURITY_READ,
            `OP_READ_ANY_REG, `OP_PARAMS_READ:
                dummy_cycles_o = (lat_code == `LAT_CODE_ZERO) ? `LAT_ZERO_DUMMY
                                 : {1'b0, lat_code};
            default:
                dummy_cycles_o = `LAT_NONE;
        endcase
    end

    // ****************************************************************
    // burst wrap
    // ****************************************************************
    assign wrap_cmd = (opcode_i == `OP_QUAD_IO_READ) || (opcode_i == `OP_QUAD_IO_READ4) ||
                      (opcode_i == `OP_DDR_QUAD_READ) ||
                      (opcode_i == `OP_DDR_QUAD_READ4);

    // a clear wrap bit means wrapping is on
    assign wrap_active_o = wrap_cmd && !live_config_i[`CFG_WRAP_OFF_BIT];

    // group of 8 << size bytes, aligned
    assign wrap_mask = {26'h0000000, wrap_size == 2'h3, wrap_size[1],
                        wrap_size != 2'h0, 3'h7};
    assign addr_inc  = addr_i + 32'h00000001;
    assign addr_next_o = wrap_active_o ? ((addr_i & ~wrap_mask) | (addr_inc & wrap_mask))
                                       : addr_inc;

endmodule // read_timing_decode

// file: read_boot_config_checker_assertions.sv
// assertion checker for the read wrap and latency boot configuration block
`timescale 1ns/100ps
module read_boot_config_checker
(
    input wire        clock_i,
    input wire        reset_i,
    input wire        cs_n_i,
    input wire        so_oe_o,
    input wire        hard_reset_i,
    input wire        soft_reset_i,
    input wire [7:0]  read_opcode_i,
    input wire [31:0] read_addr_i,
    input wire [4:0]  latency_cycles_o,
    input wire        wrap_active_o,
    input wire [31:0] read_addr_next_o,
    input wire [7:0]  boot_config_o,
    input wire [7:0]  live_config_o,
    input wire        wrap_on_o,
    input wire [3:0]  latency_code_o
);
    // ********
    // port relations
    // ********
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    wire        fix_op = read_opcode_i inside {8'h41, 8'h2b, 8'ha7, 8'he7};
    wire        wrp_op = read_opcode_i inside {8'heb, 8'hec, 8'hed, 8'hee};
    wire        var_op = wrp_op || (read_opcode_i inside {8'h0b, 8'h0c, 8'h3b, 8'h3c,
                         8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'h4b, 8'h5a});
    wire [31:0] grp    = (32'h8 << live_config_o[6:5]) - 32'h1;
    wire [31:0] inc    = read_addr_i + 32'h1;
    wire [4:0]  lat    = (latency_code_o == 4'h0) ? 5'h08 : {1'b0, latency_code_o};

    property p_rsvd; boot_config_o[7] == 1'b0 && live_config_o[7] == 1'b0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_pol; wrap_on_o == !live_config_o[4]; endproperty
    a_pol: assert property (p_pol) else $error("wrap polarity wrong");
    property p_wcmd; wrap_active_o == (wrp_op && !live_config_o[4]); endproperty
    a_wcmd: assert property (p_wcmd) else $error("wrap on wrong command");
    property p_fix; fix_op |-> latency_cycles_o == 5'h01; endproperty
    a_fix: assert property (p_fix) else $error("fixed latency wrong");
    property p_var; var_op |-> latency_cycles_o == lat; endproperty
    a_var: assert property (p_var) else $error("variable latency wrong");
    property p_wadr;
        wrap_active_o |-> ((read_addr_next_o & ~grp) == (read_addr_i & ~grp))
            && ((read_addr_next_o & grp) == (inc & grp));
    endproperty
    a_wadr: assert property (p_wadr) else $error("wrapped address wrong");
    property p_sadr; !wrap_active_o |-> read_addr_next_o == inc; endproperty
    a_sadr: assert property (p_sadr) else $error("sequential address wrong");
    property p_soft; soft_reset_i |=> live_config_o == $past(boot_config_o); endproperty
    a_soft: assert property (p_soft) else $error("soft reset load missing");
    property p_hard; $rose(hard_reset_i) |-> ##[1:8] live_config_o == boot_config_o; endproperty
    a_hard: assert property (p_hard) else $error("hard reset load missing");
    property p_bcs; $changed(boot_config_o) |-> !cs_n_i; endproperty
    a_bcs: assert property (p_bcs) else $error("boot changed outside frame");
    property p_oe; cs_n_i [*5] |=> !so_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("output enabled while idle");
endmodule // read_boot_config_checker

bind read_wrap_latency_boot_config read_boot_config_checker u_chk
(
    .clock_i(clock_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o),
    .hard_reset_i(hard_reset_i), .soft_reset_i(soft_reset_i), .read_opcode_i(read_opcode_i),
    .read_addr_i(read_addr_i), .latency_cycles_o(latency_cycles_o),
    .wrap_active_o(wrap_active_o), .read_addr_next_o(read_addr_next_o),
    .boot_config_o(boot_config_o), .live_config_o(live_config_o), .wrap_on_o(wrap_on_o),
    .latency_code_o(latency_code_o)
);

// file: spi_host_model.sv
// serial host model driving the configuration block in mode 0
`timescale 1ns/100ps
module spi_host_model
(
    input  wire clock_i,
    input  wire so_i,
    output reg  sck_o,
    output reg  cs_n_o,
    output reg  si_o
);
    // ********
    // frame engine
    // ********
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    // 160 ns period stays below the lowest listed limit of any code
    task half;
        begin
            repeat (4) @(posedge clock_i);
            #1;
        end
    endtask
    task shift(input [31:0] v, input integer n, output [31:0] r);
        integer k;
        begin
            r = 32'h0;
            for (k = n - 1; k >= 0; k = k - 1)
            begin
                si_o = v[k];
                half;
                sck_o = 1'b1;
                r = {r[30:0], so_i};
                half;
                sck_o = 1'b0;
            end
        end
    endtask
    // header, dummy edges, then data; only data edges are returned
    task frame(input [31:0] h, input integer nh, input integer nd, input [31:0] d,
               input integer n, output [31:0] r);
        begin
            cs_n_o = 1'b0;
            half;
            shift(h, nh, r);
            shift(32'h0, nd, r);
            shift(d, n, r);
            half;
            cs_n_o = 1'b1;
            // line is released; toggling keeps a stale sample from passing
            si_o = ~si_o;
            half;
        end
    endtask
endmodule // spi_host_model

// file: read_wrap_latency_boot_config_tb_top.sv
// self-checking bench for the read wrap and latency boot configuration block
`timescale 1ns/100ps
module read_wrap_latency_boot_config_tb_top;
    reg         clock_i;
    reg         reset_i;
    reg         hard_reset_i;
    reg         soft_reset_i;
    reg  [7:0]  read_opcode_i;
    reg  [31:0] read_addr_i;
    wire        sck, cs_n, si, so, so_oe, wrap_on, wrap_act;
    // nothing pulls the released line, so it shows the inverse of its last value
    wire        so_seen = so_oe ? so : ~so;
    wire [4:0]  lat_cyc;
    wire [31:0] next_addr;
    wire [7:0]  boot, live;
    wire [1:0]  wrap_size;
    wire [3:0]  lat_code;
    integer     n_errors, n_tests, i, k;
    reg  [31:0] seed, r;
    reg  [7:0]  d, e;
    localparam [151:0] op_table = {8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc,
        8'heb, 8'hec, 8'hed, 8'hee, 8'h4b, 8'h5a, 8'h41, 8'h2b, 8'ha7, 8'he7, 8'h03};

    read_wrap_latency_boot_config u_dut
    (
        .clock_i(clock_i), .reset_i(reset_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .so_o(so), .so_oe_o(so_oe), .hard_reset_i(hard_reset_i), .soft_reset_i(soft_reset_i),
        .read_opcode_i(read_opcode_i), .read_addr_i(read_addr_i), .latency_cycles_o(lat_cyc),
        .wrap_active_o(wrap_act), .read_addr_next_o(next_addr), .boot_config_o(boot),
        .live_config_o(live), .wrap_on_o(wrap_on), .wrap_size_o(wrap_size),
        .latency_code_o(lat_code)
    );
    spi_host_model u_host
    (
        .clock_i(clock_i), .so_i(so_seen), .sck_o(sck), .cs_n_o(cs_n), .si_o(si)
    );

    // ********
    // expectations and reporting
    // ********
    function [31:0] rnd(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            rnd = x ^ (x << 5);
        end
    endfunction
    function [4:0] exp_lat(input [7:0] op, input [3:0] c);
        case (op)
            8'h41, 8'h2b, 8'ha7, 8'he7: exp_lat = 5'h01;
            8'h03: exp_lat = 5'h00;
            default: exp_lat = (c == 4'h0) ? 5'h08 : {1'b0, c};
        endcase
    endfunction
    function wrp(input [7:0] op, input [7:0] lv);
        wrp = (op == 8'heb || op == 8'hec || op == 8'hed || op == 8'hee) && !lv[4];
    endfunction
    function [31:0] exp_next(input [7:0] op, input [7:0] lv, input [31:0] ad);
        reg [31:0] m;
        begin
            m = (32'h8 << lv[6:5]) - 32'h1;
            exp_next = wrp(op, lv) ? (ad & ~m) | ((ad + 32'h1) & m) : ad + 32'h1;
        end
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            if (n_errors == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // ********
    // stimulus
    // ********
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    initial
    begin
        #1000000;
        n_errors = n_errors + 1;
        close_out;
    end
    initial
    begin
        n_errors = 0;
        n_tests = 0;
        seed = 32'h00004f7c;
        reset_i = 1'b1;
        hard_reset_i = 1'b0;
        soft_reset_i = 1'b0;
        read_opcode_i = 8'h00;
        read_addr_i = 32'h0;
        repeat (20) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        repeat (4) @(posedge clock_i);
        #1;
        check(boot, 8'h70);
        check(live, 8'h70);
        check(wrap_on, 1'b0);
        check(wrap_size, 2'h3);
        check(lat_code, 4'h0);
        u_host.frame(32'h71000004, 32, 0, 32'h55, 8, r);
        check(boot, 8'h70);
        u_host.frame(32'h65000010, 32, 8, 32'h0, 8, r);
        check(r[7:0], 8'h00);
        e = 8'h70;
        for (i = 0; i < 6; i = i + 1)
        begin
            seed = rnd(seed);
            d = seed[7:0];
            // first four passes cover every wrap size with wrapping on, the fifth size 0 with wrapping off; all five set the reserved bit
            if (i < 5)
                d[7:4] = {1'b1, i[1:0], i[2]};
            if (i == 0)
                d[3:0] = 4'h0;
            u_host.frame(32'h06, 8, 0, 32'h0, 0, r);
            if (i == 3)
                u_host.frame(32'h01, 8, 0, {24'h0, d}, 32, r);
            else
                u_host.frame(32'h71000004, 32, 0, {24'h0, d}, 8, r);
            check(boot, d & 8'h7f);
            check(live, e);
            e = d & 8'h7f;
            if (i[0])
                hard_reset_i = 1'b1;
            else
                soft_reset_i = 1'b1;
            repeat (2) @(posedge clock_i);
            #1;
            hard_reset_i = 1'b0;
            soft_reset_i = 1'b0;
            repeat (8) @(posedge clock_i);
            #1;
            check(live, e);
            check(wrap_on, !e[4]);
            check(wrap_size, e[6:5]);
            check(lat_code, e[3:0]);
            u_host.frame(32'h65000004, 32, (e[3:0] == 4'h0) ? 8 : e[3:0], 32'h0, 8, r);
            check(r[7:0], e);
            for (k = 0; k < 19; k = k + 1)
            begin
                seed = rnd(seed);
                read_opcode_i = op_table[8 * k +: 8];
                read_addr_i = seed;
                @(posedge clock_i);
                #1;
                check(lat_cyc, exp_lat(read_opcode_i, e[3:0]));
                check(wrap_act, wrp(read_opcode_i, e));
                check(next_addr, exp_next(read_opcode_i, e, seed));
            end
        end
        // the unlock was used up by the last write frame
        u_host.frame(32'h71000004, 32, 0, {24'h0, ~e}, 8, r);
        check(boot, e);
        // mid-run power-on reset restores the factory value
        reset_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        @(posedge clock_i);
        #1;
        check(boot, 8'h70);
        check(live, 8'h70);
        u_host.frame(32'h65000004, 32, 8, 32'h0, 8, r);
        check(r[7:0], 8'h70);
        close_out;
    end
endmodule // read_wrap_latency_boot_config_tb_top
